// [hw/e1pm_top.sv]
// Per-port test logic: pattern insertion on transmit, pattern checking
// on receive, one-channel octet monitors in both directions and the
// byte-wide register port. Assumes link clocks, frame marks and data
// arrive as pins, much slower than the system clock.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module e1pm_top (
   // System clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Receive link pins
   input  wire logic       rx_clk,
   input  wire logic       rx_frame,
   input  wire logic       rx_data,
   // Transmit link pins
   input  wire logic       tx_clk,
   input  wire logic       tx_frame,
   input  wire logic       tx_data_in,
   output logic            tx_data_out,
   // E-bit error event from the framer
   input  wire logic       ebit_err,
   // Control levels and user outputs
   output logic            line_iface_reset,
   output logic            rx_elastic_align,
   output logic            rx_elastic_reset,
   output logic            user_output_a,
   output logic            user_output_b
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0]  tx_ctrl;
      logic [7:0]  rx_ctrl;
      logic [7:0]  pat_ctrl;
      logic [7:0]  rx_mon;
      logic [7:0]  tx_mon;
      logic [7:0]  rx_shift;
      logic [7:0]  tx_shift;
      logic [7:0]  rx_cnt;
      logic [7:0]  tx_cnt;
      logic [15:0] err_cnt;
      logic [7:0]  rdata;
      logic        tx_bit;
      logic        err_lvl;
      logic        out_a;
      logic        out_b;
   } e1pm_top_t;

   e1pm_top_t st_q;
   e1pm_top_t st_d;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Each half period of a link clock must span two system clocks, or
   // its edges are lost: sampling was chosen over a second clock domain

   logic [2:0] rx_pins;
   logic [2:0] tx_pins;
   logic       rx_rise;
   logic       tx_rise;

   e1pm_sync #(
      .W(3)
   ) u_rx_sync (
      .clk      (sys_clk),
      .rst      (rst),
      .pin      ({rx_frame, rx_data, rx_clk}),
      .pin_sync (rx_pins),
      .clk_rise (rx_rise)
   );

   e1pm_sync #(
      .W(3)
   ) u_tx_sync (
      .clk      (sys_clk),
      .rst      (rst),
      .pin      ({tx_frame, tx_data_in, tx_clk}),
      .pin_sync (tx_pins),
      .clk_rise (tx_rise)
   );

   ////////////////////////////////////////////////////////////////////////
   // Frame position of the bit sampled at this link edge

   logic [7:0] rx_pos;
   logic [7:0] tx_pos;
   logic [4:0] rx_slot;
   logic [4:0] tx_slot;
   logic [4:0] rx_sel;
   logic [4:0] tx_sel;
   logic [1:0] rx_mode;
   logic [1:0] tx_mode;
   logic       rx_hit;
   logic       tx_hit;

   // A frame mark travels with the first bit of the frame
   // Without marks the position simply wraps every 256 bits
   assign rx_pos  = rx_pins[2] ? 8'h00 : st_q.rx_cnt + 8'h01;
   assign tx_pos  = tx_pins[2] ? 8'h00 : st_q.tx_cnt + 8'h01;
   assign rx_slot = rx_pos[7:3];
   assign tx_slot = tx_pos[7:3];

   // Select fields hold the plain channel number
   assign rx_sel  = st_q.rx_ctrl[e1pm_pkg::SEL_MSB:0]; // R01 R17
   assign tx_sel  = st_q.tx_ctrl[e1pm_pkg::SEL_MSB:0]; // R16 R17
   assign rx_hit  = rx_slot == rx_sel;
   assign tx_hit  = tx_slot == tx_sel;

   assign rx_mode = st_q.pat_ctrl[e1pm_pkg::RX_MODE_LO +: 2]; // R05
   assign tx_mode = st_q.pat_ctrl[e1pm_pkg::TX_MODE_LO +: 2]; // R05

   ////////////////////////////////////////////////////////////////////////
   // Slot gating per pattern mode

   logic rx_take;
   logic tx_put;

   always_comb begin
      case (rx_mode)
         e1pm_pkg::MODE_SINGLE: rx_take = rx_hit; // R09
         e1pm_pkg::MODE_FRAMED: begin
            rx_take = rx_slot != e1pm_pkg::SLOT_FRAME; // R10
         end
         e1pm_pkg::MODE_ALL:    rx_take = 1'b1; // R11
         default:               rx_take = 1'b0;
      endcase
   end

   always_comb begin
      case (tx_mode)
         // The select field names the pattern slot in this mode
         e1pm_pkg::MODE_SINGLE: tx_put = tx_hit; // R06
         e1pm_pkg::MODE_FRAMED: begin
            tx_put = tx_slot != e1pm_pkg::SLOT_FRAME; // R07
         end
         e1pm_pkg::MODE_ALL:    tx_put = 1'b1; // R08
         default:               tx_put = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Pattern engine

   logic gen_bit;
   logic synced;
   logic bit_err;
   logic gen_step;
   logic chk_step;
   logic rx_on;

   // One generator step per inserted bit, one check per examined bit
   assign gen_step = tx_rise & tx_put;
   assign chk_step = rx_rise & rx_take;
   // Setting the receive mode back to off forgets sync and the error history
   assign rx_on    = rx_mode != e1pm_pkg::MODE_OFF;

   e1pm_prbs u_prbs (
      .clk       (sys_clk),
      .rst       (rst),
      .gen_step  (gen_step),
      .gen_bit   (gen_bit),
      .chk_clear (~rx_on),
      .chk_step  (chk_step),
      .chk_bit   (rx_pins[1]),
      .synced    (synced),
      .bit_err   (bit_err)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state

   logic       cnt_inc;
   logic       tx_next;
   logic [7:0] rx_sh;
   logic [7:0] tx_sh;
   logic       rx_last;
   logic       tx_last;
   logic       err_en_a;
   logic       err_en_b;

   assign tx_next = tx_put ? gen_bit : tx_pins[1]; // R04
   assign rx_sh   = {st_q.rx_shift[6:0], rx_pins[1]}; // R02
   assign tx_sh   = {st_q.tx_shift[6:0], tx_next};

   // Last bit of the selected slot closes the octet; in mode 1 the
   // select field still feeds the monitor as well as the pattern slot
   assign rx_last = rx_hit && rx_pos[2:0] == e1pm_pkg::LAST_BIT;
   assign tx_last = tx_hit && tx_pos[2:0] == e1pm_pkg::LAST_BIT;

   // Error outputs stay quiet unless software enables them
   assign err_en_a = st_q.pat_ctrl[e1pm_pkg::ERR_A_BIT];
   assign err_en_b = st_q.pat_ctrl[e1pm_pkg::ERR_B_BIT];

   // Pattern errors take over the counter in any checking mode
   assign cnt_inc = (rx_mode != e1pm_pkg::MODE_OFF) ? bit_err // R14
                                                    : ebit_err;

   always_comb begin
      st_d       = st_q;
      st_d.rdata = e1pm_pkg::BYTE_ZERO;

      // Receive side, one link bit per detected edge
      if (rx_rise) begin
         st_d.rx_cnt   = rx_pos;
         st_d.rx_shift = rx_sh;
         st_d.err_lvl  = 1'b0;
         // Whole octet only, so a read never sees a partial one
         if (rx_last) begin
            st_d.rx_mon = rx_sh; // R20 R01 R02
         end
      end

      // Error level lasts until the next receive clock edge
      if (bit_err) begin
         st_d.err_lvl = 1'b1; // R15
      end
      st_d.out_a = st_d.err_lvl & err_en_a; // R15
      st_d.out_b = st_d.err_lvl & err_en_b; // R15

      // Transmit side; the output bit trails the link edge by three
      // system clocks, well inside one link bit
      if (tx_rise) begin
         st_d.tx_cnt   = tx_pos;
         st_d.tx_shift = tx_sh;
         st_d.tx_bit   = tx_next; // R06 R07 R08
         if (tx_last) begin
            st_d.tx_mon = tx_sh; // R16
         end
      end

      // Saturating error counter, cleared only by reset, so software
      // works on the difference between two readings
      if (cnt_inc && st_q.err_cnt != e1pm_pkg::CNT_MAX) begin
         st_d.err_cnt = st_q.err_cnt + 16'h0001; // R14
      end

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            e1pm_pkg::REG_TX_CTRL:  st_d.tx_ctrl  = reg_wdata;
            e1pm_pkg::REG_RX_CTRL:  st_d.rx_ctrl  = reg_wdata; // R03
            e1pm_pkg::REG_PAT_CTRL: st_d.pat_ctrl = reg_wdata; // R05
            default: begin
            end
         endcase
      end

      // Counter bytes are read one at a time with no latch between
      // them, so a carry may fall between the two reads
      // Register reads, data valid in the following cycle only
      if (reg_rd) begin
         case (reg_addr)
            e1pm_pkg::REG_TX_CTRL:  st_d.rdata = st_q.tx_ctrl;
            e1pm_pkg::REG_RX_CTRL:  st_d.rdata = st_q.rx_ctrl;
            e1pm_pkg::REG_PAT_CTRL: st_d.rdata = st_q.pat_ctrl;
            e1pm_pkg::REG_STATUS: begin
               st_d.rdata = e1pm_pkg::BYTE_ZERO;
               st_d.rdata[e1pm_pkg::SYNC_BIT] = synced; // R12
            end
            e1pm_pkg::REG_ERR_HI:   st_d.rdata = st_q.err_cnt[15:8];
            e1pm_pkg::REG_ERR_LO:   st_d.rdata = st_q.err_cnt[7:0];
            e1pm_pkg::REG_TX_MON:   st_d.rdata = st_q.tx_mon;
            e1pm_pkg::REG_RX_MON:   st_d.rdata = st_q.rx_mon;
            default:                st_d.rdata = e1pm_pkg::BYTE_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q          <= '0;
         st_q.tx_ctrl  <= e1pm_pkg::CTRL_RST;
         st_q.rx_ctrl  <= e1pm_pkg::CTRL_RST;
         st_q.pat_ctrl <= e1pm_pkg::CTRL_RST;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   // Control bits leave as plain levels; pulsing them is up to software

   assign reg_rdata        = st_q.rdata;
   assign tx_data_out      = st_q.tx_bit;
   assign line_iface_reset = st_q.rx_ctrl[e1pm_pkg::LINE_IFACE_RESET_BIT]; // R03
   assign rx_elastic_align = st_q.rx_ctrl[e1pm_pkg::ALIGN_BIT]; // R03
   assign rx_elastic_reset = st_q.rx_ctrl[e1pm_pkg::ESRST_BIT]; // R03
   assign user_output_a    = st_q.out_a;
   assign user_output_b    = st_q.out_b;

endmodule

// [hw/e1pm_pkg.sv]
// Constants, register map and field layout of the E1 pattern test and
// channel monitor logic. Assumes one 20 MHz system clock and a byte-wide
// register port with 8-bit addresses.
//
// Behaviour
// [R01] Receive select field picks monitored channel
// [R02] Receive monitor: first bit MSB, last LSB
// [R03] Receive control bits 7..5 drive resets, align
// [R04] Generate and check the 2^15-1 pattern
// [R05] Pattern control: tx mode 3:2, rx 1:0
// [R06] Tx mode 1: pattern in selected slot
// [R07] Tx mode 2: pattern in slots 1..31
// [R08] Tx mode 3: pattern in all 256 bits
// [R09] Rx mode 1: check selected slot only
// [R10] Rx mode 2: check slots 1..31
// [R11] Rx mode 3: check whole stream unframed
// [R12] Status bit 0 shows checker sync
// [R13] Six errors in 64 bits drop sync
// [R14] Rx mode nonzero: counter counts pattern errors
// [R15] User output pulses per error while synced
// [R16] Transmit select field picks monitored channel
// [R17] Host writes plain binary channel number
// [R18] Fifteen-stage register, taps 14 and 15
// [R19] Sync after 64 clean bits; count synced
// [R20] Monitor loads whole octet once per frame
package e1pm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] REG_TX_CTRL  = 8'h14;
   localparam logic [7:0] REG_RX_CTRL  = 8'h15;
   localparam logic [7:0] REG_PAT_CTRL = 8'h16;
   localparam logic [7:0] REG_STATUS   = 8'h17;
   localparam logic [7:0] REG_ERR_HI   = 8'h18;
   localparam logic [7:0] REG_ERR_LO   = 8'h19;
   localparam logic [7:0] REG_TX_MON   = 8'h22;
   localparam logic [7:0] REG_RX_MON   = 8'h2A;

   ////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int SEL_MSB       = 4;
   localparam int LINE_IFACE_RESET_BIT     = 7;
   localparam int ALIGN_BIT     = 6;
   localparam int ESRST_BIT     = 5;
   localparam int TX_MODE_LO    = 2;
   localparam int RX_MODE_LO    = 0;
   localparam int ERR_A_BIT     = 4;
   localparam int ERR_B_BIT     = 5;
   localparam int SYNC_BIT      = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;

   ////////////////////////////////////////////////////////////////////////
   // Pattern modes
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_FRAMED = 2'h2;
   localparam logic [1:0] MODE_ALL    = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Frame geometry and pattern checker
   localparam logic [2:0] LAST_BIT   = 3'h7;
   localparam logic [4:0] SLOT_FRAME = 5'h00;
   localparam int LFSR_LEN  = 15;
   localparam int TAP_A     = 14;
   localparam int TAP_B     = 13;
   localparam logic [14:0] LFSR_SEED = 15'h7FFF;
   localparam logic [6:0] SYNC_RUN  = 7'h3F;
   localparam int WIN_LEN   = 64;
   localparam int ERR_LIMIT = 6;

endpackage

// [hw/e1pm_sync.sv]
// Two-stage synchroniser for a group of pins plus rising-edge detect on
// bit 0, which carries the link clock. Assumes pins are slow against
// the system clock.
`timescale 1ns/1ns
module e1pm_sync #(
   parameter int W = 3
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Pins and synchronised copy
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] pin_sync,
   output logic              clk_rise
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic         last;
   } e1pm_sync_t;

   e1pm_sync_t st_q;
   e1pm_sync_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.s1   = pin;
      st_d.s2   = st_q.s1;
      st_d.last = st_q.s2[0];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pin_sync = st_q.s2;
   assign clk_rise = st_q.s2[0] & ~st_q.last;

endmodule

// [hw/e1pm_prbs.sv]
// Pattern generator and self-synchronising checker for the 2^15-1
// sequence. Steps are one-cycle enables from the owning logic.
`timescale 1ns/1ns
module e1pm_prbs (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Generator
   input  wire logic gen_step,
   output logic      gen_bit,
   // Checker
   input  wire logic chk_clear,
   input  wire logic chk_step,
   input  wire logic chk_bit,
   output logic      synced,
   output logic      bit_err
);

   typedef struct packed {
      logic [e1pm_pkg::LFSR_LEN-1:0] gen;
      logic [e1pm_pkg::LFSR_LEN-1:0] chk;
      logic [6:0]                    run;
      logic [e1pm_pkg::WIN_LEN-1:0]  hist;
      logic                          sync;
      logic                          err;
   } e1pm_prbs_t;

   e1pm_prbs_t st_q;
   e1pm_prbs_t st_d;

   function automatic int ones(input logic [e1pm_pkg::WIN_LEN-1:0] v);
      int n;
      n = 0;
      for (int i = 0; i < e1pm_pkg::WIN_LEN; i++) begin
         n = n + int'(v[i]);
      end
      return n;
   endfunction

   logic pred;
   logic miss;

   assign gen_bit = st_q.gen[e1pm_pkg::TAP_A] ^ st_q.gen[e1pm_pkg::TAP_B]; // R18
   assign pred    = st_q.chk[e1pm_pkg::TAP_A] ^ st_q.chk[e1pm_pkg::TAP_B];
   assign miss    = chk_bit ^ pred;

   always_comb begin
      st_d     = st_q;
      st_d.err = 1'b0;
      if (gen_step) begin
         st_d.gen = {st_q.gen[e1pm_pkg::LFSR_LEN-2:0], gen_bit}; // R04
      end
      if (chk_clear) begin
         st_d.run  = '0;
         st_d.sync = 1'b0;
         st_d.hist = '0;
      end else if (chk_step) begin
         // Received bits feed the register, so it locks on its own
         st_d.chk = {st_q.chk[e1pm_pkg::LFSR_LEN-2:0], chk_bit}; // R18
         if (!st_q.sync) begin
            // An all-zero register would predict zeros forever
            if (miss || st_q.chk == '0) begin
               st_d.run = '0;
            end else if (st_q.run == e1pm_pkg::SYNC_RUN) begin
               st_d.sync = 1'b1; // R19
               st_d.hist = '0;
            end else begin
               st_d.run = st_q.run + 7'h01;
            end
         end else begin
            st_d.err  = miss; // R19
            st_d.hist = {st_q.hist[e1pm_pkg::WIN_LEN-2:0], miss};
            if (ones(st_d.hist) >= e1pm_pkg::ERR_LIMIT) begin
               st_d.sync = 1'b0; // R13
               st_d.run  = '0;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q      <= '0;
         st_q.gen  <= e1pm_pkg::LFSR_SEED;
      end else begin
         st_q <= st_d;
      end
   end

   assign synced  = st_q.sync;
   assign bit_err = st_q.err;

endmodule

// [tb/e1pm_top_asserts.sv]
// Checker for the E1 pattern block: register port, control levels and
// user outputs. Assumes it is bound to e1pm_top and sees only its ports.
`timescale 1ns/1ns
module e1pm_top_asserts (
   // Clock, reset and register port
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Control levels and user outputs
   input wire logic       line_iface_reset,
   input wire logic       rx_elastic_align,
   input wire logic       rx_elastic_reset,
   input wire logic       user_output_a,
   input wire logic       user_output_b
);
   logic [7:0] rxc_q;
   logic [7:0] pat_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Shadows of the receive and pattern controls, updated like the design's own
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rxc_q <= 8'h00;
         pat_q <= 8'h00;
      end else if (reg_wr && reg_addr == e1pm_pkg::REG_RX_CTRL) begin
         rxc_q <= reg_wdata;
      end else if (reg_wr && reg_addr == e1pm_pkg::REG_PAT_CTRL) begin
         pat_q <= reg_wdata;
      end
   end

   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

   property p_unmapped;
      reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");

   property p_ctl;
      {line_iface_reset, rx_elastic_align, rx_elastic_reset} == rxc_q[7:5];
   endproperty
   a_ctl: assert property (p_ctl) else $error("control level wrong");

   property p_ctl_rd;
      reg_rd && reg_addr == e1pm_pkg::REG_RX_CTRL |=>
         reg_rdata == $past(rxc_q);
   endproperty
   a_ctl_rd: assert property (p_ctl_rd) else $error("rx ctrl read");

   property p_pat_rd;
      reg_rd && reg_addr == e1pm_pkg::REG_PAT_CTRL |=>
         reg_rdata[5:0] == $past(pat_q[5:0]);
   endproperty
   a_pat_rd: assert property (p_pat_rd) else $error("mode read");

   property p_usr_a;
      $rose(user_output_a) |-> (pat_q[4] || $past(pat_q[4]))
         && pat_q[1:0] != 2'h0;
   endproperty
   a_usr_a: assert property (p_usr_a) else $error("output a pulse");

   property p_usr_b;
      $rose(user_output_b) |-> (pat_q[5] || $past(pat_q[5]))
         && pat_q[1:0] != 2'h0;
   endproperty
   a_usr_b: assert property (p_usr_b) else $error("output b pulse");

   property p_sync_off;
      reg_rd && reg_addr == e1pm_pkg::REG_STATUS && pat_q[1:0] == 2'h0
         && $past(pat_q[1:0], 3) == 2'h0 |=> !reg_rdata[0];
   endproperty
   a_sync_off: assert property (p_sync_off) else $error("sync idle");
endmodule

bind e1pm_top e1pm_top_asserts chk_u (
   .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .line_iface_reset(line_iface_reset),
   .rx_elastic_align(rx_elastic_align),
   .rx_elastic_reset(rx_elastic_reset),
   .user_output_a(user_output_a), .user_output_b(user_output_b)
);

// [tb/e1pm_line_model.sv]
// Far-end line model: free-running link clock, a fixed octet per slot
// into the transmit path, transmit bits looped back two bits later.
`timescale 1ns/1ns
module e1pm_line_model (
   // Pins toward the block
   output logic      lclk,
   output logic      tx_frame,
   output logic      tx_data_in,
   output logic      rx_frame,
   output logic      rx_data,
   input  wire logic tx_data_out
);
   logic [7:0] pos;
   logic       cap;
   logic       fcap;
   logic       flip;
   logic       fdly;

   // Slot s carries octet 101sssss, first bit in the MSB
   function automatic logic octet(input logic [7:0] p);
      logic [7:0] b;
      b = {3'h5, p[7:3]};
      return b[3'h7 - p[2:0]];
   endfunction

   // Odd phase keeps the link unrelated to the system clock
   initial begin
      lclk = 1'b0;
      pos = 8'hFF;
      {tx_frame, tx_data_in, rx_frame, rx_data} = 4'h0;
      {cap, fcap, flip, fdly} = 4'h0;
      #37;
      forever #200 lclk = ~lclk;
   end

   // Pins move on the falling edge so they are steady at each rise
   always @(negedge lclk) begin
      pos        <= pos + 8'h01;
      tx_frame   <= pos == 8'hFF;
      tx_data_in <= octet(pos + 8'h01);
      rx_data    <= cap ^ flip;
      rx_frame   <= fcap;
   end

   // The mark waits one bit so it lands beside the bit it came with
   always @(posedge lclk) begin
      cap  <= tx_data_out;
      fdly <= tx_frame;
      fcap <= fdly;
   end

   // Inverts n looped bits, four bits apart
   task automatic inject(input int n);
      repeat (n) begin
         @(negedge lclk);
         flip <= 1'b1;
         @(negedge lclk);
         flip <= 1'b0;
         repeat (2) @(negedge lclk);
      end
   endtask
endmodule

// [tb/e1pm_top_tb.sv]
// Bench for the E1 pattern block: monitors, pattern sync in all modes,
// error counting and user outputs. Assumes the line model loops back.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   failures++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module e1pm_top_tb;
   logic        sys_clk = 1'b0;
   logic        rst;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        lclk;
   logic        tx_frame;
   logic        tx_data_in;
   logic        tx_data_out;
   logic        rx_frame;
   logic        rx_data;
   logic        ebit_err;
   logic        line_iface_reset;
   logic        rx_elastic_align;
   logic        rx_elastic_reset;
   logic        user_output_a;
   logic        user_output_b;
   logic [15:0] c0;
   logic [15:0] c1;
   int          failures = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          ua_hi = 0;
   int          ub_hi = 0;
   wire  [2:0]  ctl = {line_iface_reset, rx_elastic_align, rx_elastic_reset};

   always #25 sys_clk = ~sys_clk;

   e1pm_top dut_u (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_clk(lclk), .rx_frame(rx_frame),
      .rx_data(rx_data), .tx_clk(lclk), .tx_frame(tx_frame),
      .tx_data_in(tx_data_in), .tx_data_out(tx_data_out),
      .ebit_err(ebit_err), .line_iface_reset(line_iface_reset),
      .rx_elastic_align(rx_elastic_align),
      .rx_elastic_reset(rx_elastic_reset),
      .user_output_a(user_output_a), .user_output_b(user_output_b)
   );
   e1pm_line_model line_u (
      .lclk(lclk), .tx_frame(tx_frame), .tx_data_in(tx_data_in),
      .rx_frame(rx_frame), .rx_data(rx_data), .tx_data_out(tx_data_out)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e, string nm);
      logic [7:0] v;
      rd(a, v);
      `CHK(nm, e, v)
   endtask

   task automatic cnt(output logic [15:0] c);
      logic [7:0] h;
      logic [7:0] l;
      rd(e1pm_pkg::REG_ERR_HI, h);
      rd(e1pm_pkg::REG_ERR_LO, l);
      c = {h, l};
   endtask

   task automatic ebit(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         ebit_err <= 1'b1;
         @(posedge sys_clk);
         ebit_err <= 1'b0;
      end
   endtask

   task automatic wsync;
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < 400 && v[0] !== 1'b1; i++) begin
         repeat (100) @(posedge sys_clk);
         rd(e1pm_pkg::REG_STATUS, v);
      end
      `CHK("sync", 1'b1, v[0])
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Counters of cycles with each user output high, and the hang limit
   always @(posedge sys_clk) begin
      cyc++;
      if (user_output_a === 1'b1) ua_hi++;
      if (user_output_b === 1'b1) ub_hi++;
      if (cyc == 90000) begin
         failures++;
         final_report();
      end
   end

   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, ebit_err} = 19'h00000;
      rst = 1'b1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      rc(e1pm_pkg::REG_RX_CTRL, 8'h00, "rx_ctrl");
      rc(e1pm_pkg::REG_PAT_CTRL, 8'h00, "pat_ctrl");
      for (int i = 5; i < 8; i++) begin
         wr(e1pm_pkg::REG_RX_CTRL, 8'h01 << i);
         @(posedge sys_clk);
         #1;
         `CHK("ctl_pins", 3'h1 << (i - 5), ctl)
      end
      rc(e1pm_pkg::REG_RX_CTRL, 8'h80, "rx_ctrl");
      rc(8'h00, 8'h00, "unmapped");
      wr(e1pm_pkg::REG_RX_CTRL, 8'h06);
      wr(e1pm_pkg::REG_TX_CTRL, 8'h0F);
      repeat (4096) @(posedge sys_clk);
      rc(e1pm_pkg::REG_RX_MON, 8'hA6, "rx_mon");
      rc(e1pm_pkg::REG_TX_MON, 8'hAF, "tx_mon");
      wr(e1pm_pkg::REG_RX_CTRL, 8'h1F);
      repeat (4096) @(posedge sys_clk);
      rc(e1pm_pkg::REG_RX_MON, 8'hBF, "rx_mon31");
      ebit(3);
      cnt(c0);
      `CHK("ebit_cnt", 16'h0003, c0)
      $display("test monitors done");
      wr(e1pm_pkg::REG_TX_CTRL, 8'h05);
      wr(e1pm_pkg::REG_RX_CTRL, 8'h05);
      for (int m = 3; m > 0; m--) begin
         wr(e1pm_pkg::REG_PAT_CTRL, 8'h10 | 8'(m * 5));
         wsync();
         wr(e1pm_pkg::REG_PAT_CTRL, 8'h00);
         repeat (20) @(posedge sys_clk);
         rc(e1pm_pkg::REG_STATUS, 8'h00, "sync_off");
         $display("test mode %0d done", m);
      end
      wr(e1pm_pkg::REG_PAT_CTRL, 8'h1F);
      wsync();
      cnt(c0);
      `CHK("cnt_clean", 16'h0003, c0)
      ua_hi = 0;
      ub_hi = 0;
      line_u.inject(1);
      ebit(2);
      repeat (400) @(posedge sys_clk);
      cnt(c1);
      `CHK("err_one", 1'b1, c1 - c0 >= 16'h1 && c1 - c0 <= 16'h3)
      `CHK("pulse_a", 1'b1, ua_hi != 0)
      `CHK("quiet_b", 1'b1, ub_hi == 0)
      rc(e1pm_pkg::REG_STATUS, 8'h01, "sync_kept");
      wr(e1pm_pkg::REG_PAT_CTRL, 8'h2F);
      ua_hi = 0;
      line_u.inject(6);
      repeat (80) @(posedge sys_clk);
      rc(e1pm_pkg::REG_STATUS, 8'h00, "sync_lost");
      `CHK("pulse_b", 1'b1, ub_hi != 0)
      `CHK("quiet_a", 1'b1, ua_hi == 0)
      wsync();
      $display("test errors done");
      final_report();
   end
endmodule
